// ---- design/aap_pkg.sv ----
// package: port map, field positions and carrier types for the attribute block
package aap_pkg;
	localparam logic [9:0] PORT_ATTR_INDEX = 10'h3c0;
	localparam logic [9:0] PORT_ATTR_DATA = 10'h3c1;
	localparam logic [9:0] PORT_LUT_MASK = 10'h3c6;
	localparam logic [9:0] PORT_LUT_RD_INDEX = 10'h3c7;
	localparam logic [9:0] PORT_LUT_WR_INDEX = 10'h3c8;
	localparam logic [9:0] PORT_LUT_DATA = 10'h3c9;
	localparam logic [4:0] IDX_MODE = 5'h10;
	localparam logic [4:0] IDX_BORDER = 5'h11;
	localparam logic [4:0] IDX_PLANE = 5'h12;
	localparam logic [4:0] IDX_PAN = 5'h13;
	localparam logic [4:0] IDX_PAD = 5'h14;
	localparam int unsigned NUM_PAL = 16;
	localparam int unsigned LUT_DEPTH = 256;
	localparam int unsigned IDX_HI = 4;
	localparam int unsigned VIDEO_EN_BIT = 5;
	localparam int unsigned FLAG_BIT = 7;
	localparam int unsigned PAD_SEL_BIT = 7;
	localparam logic [7:0] PAL_MASK = 8'h3f;
	localparam logic [7:0] MASK_RESET = 8'hff;
	localparam logic [1:0] STAT_READ = 2'h3;
	localparam logic [1:0] STAT_WRITE = 2'h0;
	localparam logic [1:0] COMP_LAST = 2'h2;
	localparam logic [9:0] COMP_STRIDE = 10'h003;
	localparam logic [9:0] COMP_OFF_G = 10'h001;
	localparam int unsigned MODE_GFX_BIT = 0;
	localparam int unsigned MODE_MONO_BIT = 1;
	localparam int unsigned MODE_LINE_BIT = 2;
	localparam int unsigned MODE_BLINK_BIT = 3;
	localparam int unsigned MODE_TOP_BIT = 5;
	localparam int unsigned MODE_C256_BIT = 6;
	localparam int unsigned PLANE_HI = 3;
	localparam int unsigned SMUX_HI = 5;
	localparam int unsigned SMUX_LO = 4;
	localparam int unsigned PAN_HI = 3;
	typedef struct packed {
		logic graphics;
		logic mono;
		logic line_gfx;
		logic blink;
		logic top_pan;
		logic c256;
		logic pad_sel;
		logic video_en;
		logic [3:0] plane_en;
		logic [1:0] status_mux;
		logic [3:0] pan;
		logic [7:0] border;
	} aap_ctrl_t;
	typedef struct packed {
		logic [9:0] addr;
		logic rd;
		logic wr;
		logic [7:0] wdata;
	} aap_io_t;
endpackage

// ---- design/aap_pixel_map.sv ----
// pixel output mapping from palette entry and padding bits
`timescale 1ns/1ps
`default_nettype none
module aap_pixel_map (
	input wire logic [7:0] pal_entry,
	input wire logic [7:0] padding,
	input wire logic pad_sel,
	output logic [7:0] pixel
);
	assign pixel[7:6] = padding[3:2]; // [R04]
	assign pixel[5:4] = pad_sel ? padding[1:0] : pal_entry[5:4]; // [R03]
	assign pixel[3:0] = pal_entry[3:0];
endmodule
`default_nettype wire

// ---- design/aap_lut_ram.sv ----
// colour-lookup storage: one write port, one read port
`timescale 1ns/1ps
`default_nettype none
module aap_lut_ram (
	clk,
	we,
	waddr,
	wdata,
	raddr,
	rdata
);
	input wire logic clk;
	input wire logic we;
	input wire logic [9:0] waddr;
	input wire logic [7:0] wdata;
	input wire logic [9:0] raddr;
	output logic [7:0] rdata;
	logic [7:0] mem [0:3*aap_pkg::LUT_DEPTH-1];
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end
	assign rdata = mem[raddr];
endmodule
`default_nettype wire

// ---- design/aap_top.sv ----
// attribute registers and colour-lookup port, host i/o side
// Functional notes
// [R01] index bits 4-0 select, bit 5 enables video
// [R02] data port reaches the indexed attribute register
// [R03] mode bit 7 routes padding 1-0 to 5-4
// [R04] padding 3-2 drive pixel bits 7-6
// [R05] four-bit panning shifts image left
// [R06] mode bits select display options
// [R07] plane enables and status select bits
// [R08] write-only read index for lookup reads
// [R09] read/write index for lookup writes
// [R10] status low bits show last cycle type
// [R11] data port uses read or write index
// [R12] host can read the index/data flip-flop
// [R13] each attribute write toggles index/data
// [R14] index advances after red, green, blue
`timescale 1ns/1ps
`default_nettype none
module aap_top (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [9:0] io_addr,
	input wire logic io_rd,
	input wire logic io_wr,
	input wire logic [7:0] io_wdata,
	input wire logic flag_reset,
	input wire logic [3:0] pixel_in,
	output logic [7:0] io_rdata,
	output logic [7:0] pixel_out,
	output logic video_en,
	output logic [7:0] mode_bits,
	output logic [3:0] plane_en,
	output logic [1:0] status_mux,
	output logic [3:0] pan_count,
	output logic [7:0] border_out,
	output logic [7:0] pixel_mask
);
	////////////////////////////////////////////////////////////////////
	// host strobe synchroniser
	aap_pkg::aap_io_t io_s1_q;
	aap_pkg::aap_io_t io_s2_q;
	logic rst_s1_q;
	logic rst_s2_q;
	always_ff @(posedge clk) begin
		io_s1_q <= '{io_addr, io_rd, io_wr, io_wdata};
		io_s2_q <= io_s1_q;
		rst_s1_q <= flag_reset;
		rst_s2_q <= rst_s1_q;
	end
	logic rd_prev_q;
	logic wr_prev_q;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rd_prev_q <= 1'b0;
			wr_prev_q <= 1'b0;
		end else begin
			rd_prev_q <= io_s2_q.rd;
			wr_prev_q <= io_s2_q.wr;
		end
	end
	wire rd_go = io_s2_q.rd & ~rd_prev_q;
	wire wr_go = io_s2_q.wr & ~wr_prev_q;
	wire [9:0] a = io_s2_q.addr;
	wire [7:0] wd = io_s2_q.wdata;

	////////////////////////////////////////////////////////////////////
	// port decode
	function automatic logic hit(input logic [9:0] ad, input logic [9:0] p);
		hit = (ad == p);
	endfunction
	wire sel_ai = hit(a, aap_pkg::PORT_ATTR_INDEX);
	wire sel_ad = hit(a, aap_pkg::PORT_ATTR_DATA);
	wire sel_mk = hit(a, aap_pkg::PORT_LUT_MASK);
	wire sel_ri = hit(a, aap_pkg::PORT_LUT_RD_INDEX);
	wire sel_wi = hit(a, aap_pkg::PORT_LUT_WR_INDEX);
	wire sel_dt = hit(a, aap_pkg::PORT_LUT_DATA);

	////////////////////////////////////////////////////////////////////
	// attribute index/data flip-flop
	logic flag_q;
	logic [5:0] aidx_q;
	wire attr_wr = wr_go & sel_ai;
	wire idx_wr = attr_wr & ~flag_q;
	wire dat_wr = attr_wr & flag_q;
	always_ff @(posedge clk) begin
		if (sys_rst | rst_s2_q) begin
			flag_q <= 1'b0;
		end else if (attr_wr) begin
			flag_q <= ~flag_q; // [R13]
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			aidx_q <= 6'h00;
		end else if (idx_wr) begin
			aidx_q <= wd[aap_pkg::VIDEO_EN_BIT:0]; // [R01]
		end
	end
	wire [4:0] aidx = aidx_q[aap_pkg::IDX_HI:0]; // [R01]

	////////////////////////////////////////////////////////////////////
	// attribute register file
	logic [7:0] pal_q [0:aap_pkg::NUM_PAL-1];
	logic [7:0] mode_q;
	logic [7:0] border_q;
	logic [7:0] plane_q;
	logic [7:0] pan_q;
	logic [7:0] pad_q;
	genvar gi;
	generate
		for (gi = 0; gi < aap_pkg::NUM_PAL; gi++) begin : g_pal
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					pal_q[gi] <= 8'h00;
				end else if (dat_wr && aidx == 5'(gi)) begin
					pal_q[gi] <= wd & aap_pkg::PAL_MASK; // [R02]
				end
			end
		end
	endgenerate
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mode_q <= 8'h00;
			border_q <= 8'h00;
			plane_q <= 8'h00;
			pan_q <= 8'h00;
			pad_q <= 8'h00;
		end else if (dat_wr) begin
			case (aidx) // [R02]
				aap_pkg::IDX_MODE: mode_q <= wd;
				aap_pkg::IDX_BORDER: border_q <= wd;
				aap_pkg::IDX_PLANE: plane_q <= wd;
				aap_pkg::IDX_PAN: pan_q <= wd;
				aap_pkg::IDX_PAD: pad_q <= wd;
				default: ;
			endcase
		end
	end
	logic [7:0] attr_rd;
	always_comb begin
		attr_rd = 8'h00;
		case (aidx)
			aap_pkg::IDX_MODE: attr_rd = mode_q;
			aap_pkg::IDX_BORDER: attr_rd = border_q;
			aap_pkg::IDX_PLANE: attr_rd = plane_q;
			aap_pkg::IDX_PAN: attr_rd = pan_q;
			aap_pkg::IDX_PAD: attr_rd = pad_q;
			default: attr_rd = aidx[aap_pkg::IDX_HI] ? 8'h00 : pal_q[aidx[3:0]];
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// control carrier
	aap_pkg::aap_ctrl_t ctrl;
	assign ctrl.graphics = mode_q[aap_pkg::MODE_GFX_BIT]; // [R06]
	assign ctrl.mono = mode_q[aap_pkg::MODE_MONO_BIT];
	assign ctrl.line_gfx = mode_q[aap_pkg::MODE_LINE_BIT];
	assign ctrl.blink = mode_q[aap_pkg::MODE_BLINK_BIT];
	assign ctrl.top_pan = mode_q[aap_pkg::MODE_TOP_BIT];
	assign ctrl.c256 = mode_q[aap_pkg::MODE_C256_BIT];
	assign ctrl.pad_sel = mode_q[aap_pkg::PAD_SEL_BIT];
	assign ctrl.video_en = aidx_q[aap_pkg::VIDEO_EN_BIT]; // [R01]
	assign ctrl.plane_en = plane_q[aap_pkg::PLANE_HI:0]; // [R07]
	assign ctrl.status_mux = plane_q[aap_pkg::SMUX_HI:aap_pkg::SMUX_LO]; // [R07]
	assign ctrl.pan = pan_q[aap_pkg::PAN_HI:0]; // [R05]
	assign ctrl.border = border_q;

	////////////////////////////////////////////////////////////////////
	// colour lookup port
	typedef enum logic [1:0] {
		CMP_R = 2'b00,
		CMP_G = 2'b01,
		CMP_B = 2'b11
	} aap_comp_t;

	////////////////////////////////////////////////////////////////////
	// component order red, green, blue
	function automatic aap_comp_t comp_next(input aap_comp_t c);
		case (c)
			CMP_R: comp_next = CMP_G;
			CMP_G: comp_next = CMP_B;
			CMP_B: comp_next = CMP_R;
			default: comp_next = CMP_R;
		endcase
	endfunction

	function automatic logic [9:0] comp_off(input aap_comp_t c);
		case (c)
			CMP_R: comp_off = '0;
			CMP_G: comp_off = aap_pkg::COMP_OFF_G;
			CMP_B: comp_off = 10'(aap_pkg::COMP_LAST);
			default: comp_off = '0;
		endcase
	endfunction
	logic [7:0] mask_q;
	logic [7:0] ridx_q;
	logic [7:0] widx_q;
	aap_comp_t rcmp_q;
	aap_comp_t wcmp_q;
	logic [1:0] stat_q;
	wire lut_wr = wr_go & sel_dt;
	wire lut_rd = rd_go & sel_dt;
	wire mask_wr = wr_go & sel_mk;
	wire widx_wr = wr_go & sel_wi;
	wire ridx_wr = wr_go & sel_ri;
	wire wlast = (wcmp_q == CMP_B);
	wire rlast = (rcmp_q == CMP_B);
	wire [9:0] woff = comp_off(wcmp_q);
	wire [9:0] roff = comp_off(rcmp_q);
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mask_q <= aap_pkg::MASK_RESET;
		end else if (mask_wr) begin
			mask_q <= wd;
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			widx_q <= 8'h00;
			wcmp_q <= CMP_R;
		end else if (widx_wr) begin
			widx_q <= wd; // [R09]
			wcmp_q <= CMP_R;
		end else if (lut_wr) begin
			widx_q <= wlast ? widx_q + 8'h01 : widx_q; // [R14]
			wcmp_q <= comp_next(wcmp_q);
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ridx_q <= 8'h00;
			rcmp_q <= CMP_R;
		end else if (ridx_wr) begin
			ridx_q <= wd; // [R08]
			rcmp_q <= CMP_R;
		end else if (lut_rd) begin
			ridx_q <= rlast ? ridx_q + 8'h01 : ridx_q; // [R14]
			rcmp_q <= comp_next(rcmp_q);
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			stat_q <= aap_pkg::STAT_WRITE;
		end else if (widx_wr) begin
			stat_q <= aap_pkg::STAT_WRITE; // [R10]
		end else if (ridx_wr) begin
			stat_q <= aap_pkg::STAT_READ; // [R10]
		end
	end
	wire [9:0] lut_waddr = 10'(widx_q) * aap_pkg::COMP_STRIDE + woff; // [R11]
	wire [9:0] lut_raddr = 10'(ridx_q) * aap_pkg::COMP_STRIDE + roff; // [R11]
	wire [7:0] lut_rdata;
	aap_lut_ram u_lut (
		.clk(clk),
		.we(lut_wr),
		.waddr(lut_waddr),
		.wdata(wd),
		.raddr(lut_raddr),
		.rdata(lut_rdata)
	);

	////////////////////////////////////////////////////////////////////
	// read mux
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		if (sel_ai) begin
			rd_mux = {flag_q, 1'b0, aidx_q}; // [R12]
		end else if (sel_ad) begin
			rd_mux = attr_rd; // [R02]
		end else if (sel_mk) begin
			rd_mux = mask_q;
		end else if (sel_ri) begin
			rd_mux = {6'h00, stat_q}; // [R10]
		end else if (sel_wi) begin
			rd_mux = widx_q; // [R09]
		end else if (sel_dt) begin
			rd_mux = lut_rdata; // [R11]
		end
	end
	logic [7:0] rdata_q;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata_q <= 8'h00;
		end else if (rd_go) begin
			rdata_q <= rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////
	// pixel path
	logic [3:0] pin_s1_q;
	logic [3:0] pin_s2_q;
	always_ff @(posedge clk) begin
		pin_s1_q <= pixel_in;
		pin_s2_q <= pin_s1_q;
	end
	wire [3:0] pidx = pin_s2_q & ctrl.plane_en; // [R07]
	wire [7:0] pix_comb;
	aap_pixel_map u_map (
		.pal_entry(pal_q[pidx]),
		.padding(pad_q),
		.pad_sel(ctrl.pad_sel),
		.pixel(pix_comb)
	);
	logic [7:0] pix_q;
	logic [7:0] modeo_q;
	logic vid_q;
	logic [3:0] plane_oq;
	logic [1:0] smux_q;
	logic [3:0] pan_oq;
	logic [7:0] bord_q;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pix_q <= 8'h00;
			modeo_q <= 8'h00;
			vid_q <= 1'b0;
			plane_oq <= 4'h0;
			smux_q <= 2'h0;
			pan_oq <= 4'h0;
			bord_q <= 8'h00;
		end else begin
			pix_q <= ctrl.video_en ? (pix_comb & mask_q) : ctrl.border;
			modeo_q <= {ctrl.pad_sel, ctrl.c256, ctrl.top_pan, 1'b0,
				ctrl.blink, ctrl.line_gfx, ctrl.mono, ctrl.graphics}; // [R06]
			vid_q <= ctrl.video_en;
			plane_oq <= ctrl.plane_en;
			smux_q <= ctrl.status_mux;
			pan_oq <= ctrl.pan; // [R05]
			bord_q <= ctrl.border;
		end
	end
	assign io_rdata = rdata_q;
	assign pixel_out = pix_q;
	assign video_en = vid_q;
	assign mode_bits = modeo_q;
	assign plane_en = plane_oq;
	assign status_mux = smux_q;
	assign pan_count = pan_oq;
	assign border_out = bord_q;
	assign pixel_mask = mask_q;
endmodule
`default_nettype wire

// ---- test/aap_top_asserts.sv ----
// checker: port-level relations of the attribute block
`timescale 1ns/1ps
`default_nettype none
module aap_top_asserts (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic io_rd,
	input wire logic io_wr,
	input wire logic [7:0] io_rdata,
	input wire logic video_en,
	input wire logic [7:0] mode_bits,
	input wire logic [3:0] plane_en,
	input wire logic [1:0] status_mux,
	input wire logic [3:0] pan_count,
	input wire logic [7:0] border_out,
	input wire logic [7:0] pixel_mask
);
	logic [2:0] wr_age_q;
	logic [2:0] rd_age_q;
	wire logic [2:0] wr_age_d = (wr_age_q == 3'h7) ? wr_age_q : wr_age_q + 3'h1;
	wire logic [2:0] rd_age_d = (rd_age_q == 3'h7) ? rd_age_q : rd_age_q + 3'h1;
	always_ff @(posedge clk) begin
		wr_age_q <= (sys_rst || io_wr) ? 3'h0 : wr_age_d;
		rd_age_q <= (sys_rst || io_rd) ? 3'h0 : rd_age_d;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////////////////
	property p_video;
		$changed(video_en) |-> wr_age_q <= 3'h3;
	endproperty
	a_video: assert property (p_video) else $error("video enable moved");
	property p_mode;
		$changed(mode_bits) |-> wr_age_q <= 3'h3;
	endproperty
	a_mode: assert property (p_mode) else $error("mode moved");
	property p_plane;
		$changed({status_mux, plane_en}) |-> wr_age_q <= 3'h3;
	endproperty
	a_plane: assert property (p_plane) else $error("plane moved");
	property p_pan;
		$changed(pan_count) |-> wr_age_q <= 3'h3;
	endproperty
	a_pan: assert property (p_pan) else $error("pan moved");
	property p_border;
		$changed(border_out) |-> wr_age_q <= 3'h3;
	endproperty
	a_border: assert property (p_border) else $error("border moved");
	property p_rdata;
		$changed(io_rdata) |-> rd_age_q <= 3'h4;
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data moved");
	property p_quiet;
		(!io_rd) [*6] |=> $stable(io_rdata);
	endproperty
	a_quiet: assert property (p_quiet) else $error("read data not held");
	property p_rst;
		$fell(sys_rst) |-> pixel_mask == 8'hff && {video_en, mode_bits} == 9'h000;
	endproperty
	a_rst: assert property (p_rst) else $error("reset values wrong");
	c_video: cover property ($rose(video_en));
	c_pan: cover property ($changed(pan_count));
	c_rdata: cover property ($changed(io_rdata));
endmodule
bind aap_top aap_top_asserts i_aap_top_asserts (.clk(clk), .sys_rst(sys_rst),
	.io_rd(io_rd), .io_wr(io_wr), .io_rdata(io_rdata), .video_en(video_en),
	.mode_bits(mode_bits), .plane_en(plane_en), .status_mux(status_mux),
	.pan_count(pan_count), .border_out(border_out), .pixel_mask(pixel_mask));
`default_nettype wire

// ---- test/aap_host.sv ----
// host model: i/o port reads and writes with held strobes
`timescale 1ns/1ps
`default_nettype none
module aap_host (
	input wire logic clk,
	input wire logic [7:0] io_rdata,
	output var aap_pkg::aap_io_t io
);
	initial io = '{addr: 10'h000, rd: 1'b0, wr: 1'b0, wdata: 8'h00};
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(negedge clk);
		io.addr = a;
		io.wdata = d;
		@(negedge clk);
		io.wr = 1'b1;
		repeat (4) @(negedge clk);
		io.wr = 1'b0;
		repeat (4) @(negedge clk);
		io.wdata = ~d;
	endtask
	task automatic rd(input logic [9:0] a, output logic [7:0] d);
		@(negedge clk);
		io.addr = a;
		@(negedge clk);
		io.rd = 1'b1;
		repeat (6) @(negedge clk);
		d = io_rdata;
		io.rd = 1'b0;
		repeat (4) @(negedge clk);
	endtask
endmodule
`default_nettype wire

// ---- test/aap_top_bench.sv ----
// bench: register access sequences against the attribute block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
	n_fail++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module aap_top_bench;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic flag_reset = 1'b0;
	logic [3:0] pixel_in = 4'h5;
	aap_pkg::aap_io_t io;
	logic [7:0] io_rdata, pixel_out, mode_bits, border_out, pixel_mask, r, r2;
	logic video_en;
	logic [3:0] plane_en, pan_count;
	logic [1:0] status_mux;
	logic [7:0] ti [6] = '{8'h05, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14};
	logic [7:0] tv [6] = '{8'h15, 8'h41, 8'h5a, 8'h3f, 8'h07, 8'h0e};
	int n_fail = 0;
	int comparisons = 0;
	int cycles = 0;
	aap_host i_aap_host (.clk(clk), .io_rdata(io_rdata), .io(io));
	aap_top i_aap_top (.clk(clk), .sys_rst(sys_rst), .io_addr(io.addr),
		.io_rd(io.rd), .io_wr(io.wr), .io_wdata(io.wdata),
		.flag_reset(flag_reset), .pixel_in(pixel_in), .io_rdata(io_rdata),
		.pixel_out(pixel_out), .video_en(video_en), .mode_bits(mode_bits),
		.plane_en(plane_en), .status_mux(status_mux), .pan_count(pan_count),
		.border_out(border_out), .pixel_mask(pixel_mask));
	initial forever #50 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_fail++;
			results();
		end
	end
	task automatic results;
		$display("checks %0d errors %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic attr(input logic [7:0] i, input logic [7:0] v);
		@(negedge clk);
		flag_reset = 1'b1;
		@(negedge clk);
		flag_reset = 1'b0;
		i_aap_host.wr(aap_pkg::PORT_ATTR_INDEX, i);
		i_aap_host.wr(aap_pkg::PORT_ATTR_INDEX, v);
	endtask
	initial begin
		repeat (8) @(negedge clk);
		sys_rst = 1'b0;
		`CHK("mask", 8'hff, pixel_mask)
		for (int k = 0; k < 6; k++) begin
			attr(ti[k], tv[k]);
			i_aap_host.rd(aap_pkg::PORT_ATTR_DATA, r);
			`CHK("attr", tv[k], r)
		end
		`CHK("mode", 8'h41, mode_bits)
		`CHK("border", 8'h5a, border_out)
		`CHK("plane", 6'h3f, {status_mux, plane_en})
		`CHK("pan", 4'h7, pan_count)
		`CHK("off", 8'h5a, pixel_out)
		attr(8'h30, 8'h80);
		repeat (8) @(negedge clk);
		`CHK("pad", 8'he5, pixel_out)
		attr(8'h30, 8'h00);
		repeat (8) @(negedge clk);
		`CHK("pix", 8'hd5, pixel_out)
		i_aap_host.wr(aap_pkg::PORT_LUT_MASK, 8'hf0);
		i_aap_host.rd(aap_pkg::PORT_LUT_MASK, r);
		repeat (4) @(negedge clk);
		`CHK("lmask", 8'hf0, r)
		`CHK("pmask", 8'hf0, pixel_mask)
		`CHK("masked", 8'hd0, pixel_out)
		@(negedge clk);
		flag_reset = 1'b1;
		@(negedge clk);
		flag_reset = 1'b0;
		i_aap_host.wr(aap_pkg::PORT_ATTR_INDEX, 8'h33);
		i_aap_host.rd(aap_pkg::PORT_ATTR_INDEX, r);
		`CHK("index", 6'h33, r[5:0])
		`CHK("video", 1'b1, video_en)
		`CHK("flag1", 1'b1, r[7])
		i_aap_host.wr(aap_pkg::PORT_ATTR_INDEX, 8'h03);
		i_aap_host.rd(aap_pkg::PORT_ATTR_INDEX, r2);
		`CHK("flag", ~r[7], r2[7])
		`CHK("pan3", 4'h3, pan_count)
		i_aap_host.wr(aap_pkg::PORT_LUT_WR_INDEX, 8'hff);
		for (int k = 0; k < 3; k++) begin
			i_aap_host.wr(aap_pkg::PORT_LUT_DATA, 8'(8'h11 * (k + 1)));
		end
		i_aap_host.rd(aap_pkg::PORT_LUT_WR_INDEX, r);
		`CHK("wr_index", 8'h00, r)
		i_aap_host.rd(aap_pkg::PORT_LUT_RD_INDEX, r);
		`CHK("stat_w", aap_pkg::STAT_WRITE, r[1:0])
		i_aap_host.wr(aap_pkg::PORT_LUT_RD_INDEX, 8'hff);
		for (int k = 0; k < 3; k++) begin
			i_aap_host.rd(aap_pkg::PORT_LUT_DATA, r);
			`CHK("lut", 8'(8'h11 * (k + 1)), r)
		end
		i_aap_host.rd(aap_pkg::PORT_LUT_RD_INDEX, r);
		`CHK("stat_r", aap_pkg::STAT_READ, r[1:0])
		i_aap_host.rd(10'h3c2, r);
		`CHK("unmapped", 8'h00, r)
		results();
	end
endmodule
`default_nettype wire
